// ===== acsp_pkg.sv
package acsp_pkg;

  // ****************************************************************
  // Widths and counts of the serial exchange
  // ****************************************************************
  localparam int         RESULT_BITS   = 12;
  localparam int         CFG_BITS      = 3;
  localparam logic [3:0] CFG_LAST      = 4'h2;  // Index of last config bit
  localparam logic [3:0] MSB_LAST      = 4'hB;  // Index of last MSB-first bit
  localparam logic [3:0] LSB_FIRST     = 4'h1;  // First bit of the repeat
  localparam logic [3:0] LSB_LAST      = 4'hB;  // Last bit of the repeat
  localparam logic [3:0] CNT_RESET     = 4'h0;

  // Falling edges from launch to output enable, minus one
  localparam logic [3:0] FIXED_OE_FALL = 4'h1;  // Second edge after select
  localparam logic [3:0] CFG_OE_FALL   = 4'h0;  // Fourth edge after start

  // ****************************************************************
  // Configuration word layout, first bit shifted in is the highest
  // ****************************************************************
  localparam int         CFG_SGL_POS   = 2;
  localparam int         CFG_ODD_POS   = 1;
  localparam int         CFG_ORDER_POS = 0;
  localparam logic [2:0] CFG_RESET     = 3'h0;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ACSP_OFF,
    ACSP_HUNT,
    ACSP_CFG,
    ACSP_SAMPLE,
    ACSP_MSB,
    ACSP_LSB,
    ACSP_ZERO
  } acsp_state_t;

endpackage : acsp_pkg

// ===== acsp_edge.sv
`timescale 1ns/100ps

// ****************************************************************
// Edge finder for the host shift clock
// ****************************************************************
module acsp_edge (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev;
  logic next_prev;

  // Pulses last one cycle, in the cycle the new level is first seen
  always_comb begin
    next_prev = level;
    rise      = level & ~prev;
    fall      = prev & ~level;
  end

  // Idle shift clock is taken as low after reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

endmodule : acsp_edge

// ===== acsp_sar.sv
`timescale 1ns/100ps

// ****************************************************************
// Successive approximation register, one bit per step
// ****************************************************************
module acsp_sar #(
  parameter int WIDTH = acsp_pkg::RESULT_BITS
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             comp_ge,
  output logic      [WIDTH-1:0] trial_code,
  output logic      [WIDTH-1:0] result
);

  logic [WIDTH-1:0] mask;
  logic [WIDTH-1:0] next_mask;
  logic [WIDTH-1:0] next_result;
  logic [WIDTH-1:0] next_trial;

  // Start holds the sample and tries the top bit; each step keeps or
  // drops the bit under trial and moves one place down
  always_comb begin
    next_mask   = mask;
    next_result = result;
    if (start) begin
      next_mask   = {1'b1, {(WIDTH-1){1'b0}}};
      next_result = '0;
    end else if (step) begin
      next_result = comp_ge ? (result | mask) : result;
      next_mask   = mask >> 1;
    end
    next_trial = next_result | next_mask;
  end

  // Trial code is registered so the DAC sees a clean word
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mask       <= '0;
      result     <= '0;
      trial_code <= '0;
    end else begin
      mask       <= next_mask;
      result     <= next_result;
      trial_code <= next_trial;
    end
  end

endmodule : acsp_sar

// ===== acsp_port.sv
`timescale 1ns/100ps

// Behaviour
// - Device runs only while select is low; high powers it down
// - Bits launch on falling shift clock, are sampled on rising edges
// - Host shift clock paces transfer and the approximation steps
// - Fixed variant starts on select falling, takes no config word
// - Fixed variant enables output at second clock, then a null bit
// - Select high abandons any exchange and returns to idle
// - Zeros before the first one are dropped; the one is start
// - Three config bits follow start; last one launches conversion
// - Configurable variant samples data input on rising clock
// - Data input ignored after config until select cycles again
// - After config a null bit, then the result, is sent
// - Result goes MSB first, then by default repeated LSB first
// - After the data, every further clock shifts out a zero
// - Core powers down at end of conversion; shifting continues
// - Shared data wire; host releases it before device drives
// - First two config bits pick single-ended or difference pairing
// - Order bit one gives zeros after MSB data, zero the repeat
// - Device drives line low on fourth falling edge after start
module acsp_port #(
  parameter bit FIXED_INPUT = 1'b0,  // 1: fixed differential variant
  parameter int WIDTH       = acsp_pkg::RESULT_BITS
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             select_n_powerdown,
  input  wire logic             shift_clk,
  input  wire logic             data_in,
  input  wire logic             comp_ge,
  output logic                  data_out,
  output logic                  data_out_oe,
  output logic                  core_active,
  output logic                  sample_track,
  output logic      [WIDTH-1:0] dac_code,
  output logic                  pos_is_input_one,
  output logic                  neg_is_ground,
  output logic                  neg_is_input_one
);

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  acsp_pkg::acsp_state_t state;
  acsp_pkg::acsp_state_t next_state;
  logic [3:0]            cnt;
  logic [3:0]            next_cnt;
  logic [2:0]            cfg_word;
  logic [2:0]            next_cfg_word;
  logic [2:0]            shifted_cfg;
  logic                  next_data_out;
  logic                  next_oe;
  logic                  next_core;
  logic                  next_track;
  logic                  next_pos_one;
  logic                  next_neg_gnd;
  logic                  next_neg_one;
  logic                  clk_rise;
  logic                  clk_fall;
  logic                  sar_start;
  logic                  sar_step;
  logic [WIDTH-1:0]      result;
  logic [3:0]            oe_target;

  // Shift clock is the only pace of the exchange and of the SAR
  acsp_edge u_edge (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .level   (shift_clk),
    .rise    (clk_rise),
    .fall    (clk_fall)
  );

  acsp_sar #(
    .WIDTH (WIDTH)
  ) u_sar (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .start      (sar_start),
    .step       (sar_step),
    .comp_ge    (comp_ge),
    .trial_code (dac_code),
    .result     (result)
  );

  // The two variants reach the enable point after different edge counts
  assign oe_target = FIXED_INPUT ? acsp_pkg::FIXED_OE_FALL
                                 : acsp_pkg::CFG_OE_FALL;

  // Config bits arrive first bit highest, so shift in from the bottom
  assign shifted_cfg = {cfg_word[1:0], data_in};

  // ****************************************************************
  // Next-state logic of the exchange
  // ****************************************************************
  // Select high beats any clock edge seen in the same cycle, so a late
  // edge can never restart an abandoned exchange
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_cfg_word = cfg_word;
    next_data_out = data_out;
    next_oe       = data_out_oe;
    next_core     = core_active;
    next_track    = sample_track;
    next_pos_one  = pos_is_input_one;
    next_neg_gnd  = neg_is_ground;
    next_neg_one  = neg_is_input_one;
    sar_start     = 1'b0;
    sar_step      = 1'b0;
    if (select_n_powerdown) begin
      next_state    = acsp_pkg::ACSP_OFF;
      next_cnt      = acsp_pkg::CNT_RESET;
      next_oe       = 1'b0;
      next_data_out = 1'b0;
      next_core     = 1'b0;
      next_track    = 1'b0;
    end else begin
      case (state)
        acsp_pkg::ACSP_OFF: begin
          next_cnt = acsp_pkg::CNT_RESET;
          if (FIXED_INPUT) begin
            // Select falling alone opens the exchange
            next_state    = acsp_pkg::ACSP_SAMPLE;
            next_cfg_word = acsp_pkg::CFG_RESET;
            next_core     = 1'b1;
            next_track    = 1'b1;
            next_pos_one  = 1'b0;
            next_neg_gnd  = 1'b0;
            next_neg_one  = 1'b1;
          end else begin
            next_state = acsp_pkg::ACSP_HUNT;
          end
        end
        acsp_pkg::ACSP_HUNT: begin
          // Leading zeros are dropped; the first one is the start bit
          if (clk_rise && data_in) begin
            next_state = acsp_pkg::ACSP_CFG;
            next_cnt   = acsp_pkg::CNT_RESET;
          end
        end
        acsp_pkg::ACSP_CFG: begin
          if (clk_rise) begin
            next_cfg_word = shifted_cfg;
            next_cnt      = cnt + 4'h1;
            if (cnt == acsp_pkg::CFG_LAST) begin
              // Last config bit sets the mux and launches conversion
              next_state   = acsp_pkg::ACSP_SAMPLE;
              next_cnt     = acsp_pkg::CNT_RESET;
              next_core    = 1'b1;
              next_track   = 1'b1;
              next_pos_one = shifted_cfg[acsp_pkg::CFG_ODD_POS];
              next_neg_gnd = shifted_cfg[acsp_pkg::CFG_SGL_POS];
              next_neg_one = ~shifted_cfg[acsp_pkg::CFG_SGL_POS] &
                             ~shifted_cfg[acsp_pkg::CFG_ODD_POS];
            end
          end
        end
        acsp_pkg::ACSP_SAMPLE: begin
          // Data input no longer looked at from here on
          if (clk_fall) begin
            next_cnt = cnt + 4'h1;
            if (cnt == oe_target) begin
              // Output turns on with the null bit and the sample holds
              next_oe       = 1'b1;
              next_data_out = 1'b0;
              next_track    = 1'b0;
              next_state    = acsp_pkg::ACSP_MSB;
              next_cnt      = acsp_pkg::CNT_RESET;
              sar_start     = 1'b1;
            end
          end
        end
        acsp_pkg::ACSP_MSB: begin
          // Each falling edge decides one bit and launches it at once
          if (clk_fall) begin
            next_data_out = comp_ge;
            sar_step      = 1'b1;
            next_cnt      = cnt + 4'h1;
            if (cnt == acsp_pkg::MSB_LAST) begin
              next_core = 1'b0;
              next_cnt  = acsp_pkg::LSB_FIRST;
              if (cfg_word[acsp_pkg::CFG_ORDER_POS]) begin
                next_state = acsp_pkg::ACSP_ZERO;
              end else begin
                next_state = acsp_pkg::ACSP_LSB;
              end
            end
          end
        end
        acsp_pkg::ACSP_LSB: begin
          // Lowest bit is not sent twice; the repeat starts one above
          if (clk_fall) begin
            next_data_out = result[cnt];
            next_cnt      = cnt + 4'h1;
            if (cnt == acsp_pkg::LSB_LAST) begin
              next_state = acsp_pkg::ACSP_ZERO;
            end
          end
        end
        acsp_pkg::ACSP_ZERO: begin
          if (clk_fall) begin
            next_data_out = 1'b0;
          end
        end
        default: begin
          next_state = acsp_pkg::ACSP_OFF;
        end
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Every output but dac_code leaves this block from one of these flops
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state            <= acsp_pkg::ACSP_OFF;
      cnt              <= acsp_pkg::CNT_RESET;
      cfg_word         <= acsp_pkg::CFG_RESET;
      data_out         <= 1'b0;
      data_out_oe      <= 1'b0;
      core_active      <= 1'b0;
      sample_track     <= 1'b0;
      pos_is_input_one <= 1'b0;
      neg_is_ground    <= 1'b0;
      neg_is_input_one <= 1'b0;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      cfg_word         <= next_cfg_word;
      data_out         <= next_data_out;
      data_out_oe      <= next_oe;
      core_active      <= next_core;
      sample_track     <= next_track;
      pos_is_input_one <= next_pos_one;
      neg_is_ground    <= next_neg_gnd;
      neg_is_input_one <= next_neg_one;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_last_msb;
    state == acsp_pkg::ACSP_MSB && cnt == acsp_pkg::MSB_LAST &&
      clk_fall && !select_n_powerdown;
  endsequence

  sequence s_enable_point;
    state == acsp_pkg::ACSP_SAMPLE && cnt == oe_target &&
      clk_fall && !select_n_powerdown;
  endsequence

  property p_off_quiet;
    select_n_powerdown |=> !data_out_oe && !core_active && !data_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("output or core active while deselected");

  property p_launch_on_fall;
    $changed(data_out) |-> $past(clk_fall) || $past(select_n_powerdown);
  endproperty
  a_launch_on_fall: assert property (p_launch_on_fall)
    else $error("data out changed without a falling clock");

  property p_sample_on_rise;
    $changed(cfg_word) |-> $past(clk_rise) || $past(state) ==
      acsp_pkg::ACSP_OFF;
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise)
    else $error("config changed without a rising clock");

  property p_enable_cause;
    $rose(data_out_oe) |-> $past(state) == acsp_pkg::ACSP_SAMPLE &&
      $past(clk_fall) && !data_out;
  endproperty
  a_enable_cause: assert property (p_enable_cause)
    else $error("output enabled away from the enable point");

  property p_enable_point;
    s_enable_point |=> data_out_oe && !data_out &&
      state == acsp_pkg::ACSP_MSB && !sample_track;
  endproperty
  a_enable_point: assert property (p_enable_point)
    else $error("null bit missing at enable point");

  property p_zero_fill;
    state == acsp_pkg::ACSP_ZERO && clk_fall && !select_n_powerdown
      |=> !data_out;
  endproperty
  a_zero_fill: assert property (p_zero_fill)
    else $error("non-zero bit after data transfer");

  property p_core_down;
    s_last_msb |=> !core_active ##1 !core_active;
  endproperty
  a_core_down: assert property (p_core_down)
    else $error("core still active after conversion");

  property p_restart;
    $rose(select_n_powerdown) |=> state == acsp_pkg::ACSP_OFF &&
      !data_out_oe;
  endproperty
  a_restart: assert property (p_restart)
    else $error("exchange not abandoned on select high");

  property p_leading_zero;
    state == acsp_pkg::ACSP_HUNT && !data_in && !select_n_powerdown
      |=> state == acsp_pkg::ACSP_HUNT;
  endproperty
  a_leading_zero: assert property (p_leading_zero)
    else $error("leading zero taken as start");

  property p_order;
    s_last_msb |=> (state == acsp_pkg::ACSP_ZERO) ==
      cfg_word[acsp_pkg::CFG_ORDER_POS];
  endproperty
  a_order: assert property (p_order)
    else $error("wrong sequence after MSB-first data");

  property p_ignore_din;
    state == acsp_pkg::ACSP_SAMPLE |=> $stable(cfg_word);
  endproperty
  a_ignore_din: assert property (p_ignore_din)
    else $error("data input taken after config word");

endmodule : acsp_port

// ===== acsp_host.sv
`timescale 1ns/100ps

// ****************************************************************
// Host side model: select, shift clock and shared data line
// ****************************************************************
module acsp_host (
  input  wire logic ref_clk,
  input  wire logic data_wire,
  output logic      select_n_powerdown,
  output logic      shift_clk,
  output logic      host_d,
  output logic      host_oe
);
  // Idle: deselected, clock parked low, line released
  initial begin
    select_n_powerdown = 1'b1;
    shift_clk          = 1'b0;
    host_d             = 1'b0;
    host_oe            = 1'b0;
  end

  // Sample the line just before raising the clock
  task automatic rise(output logic seen);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    seen = data_wire;
    @(posedge ref_clk);
    shift_clk <= 1'b1;
  endtask : rise

  // Release after the hold time, before the device may drive
  task automatic fall(input logic release_line);
    repeat (2) @(posedge ref_clk);
    if (release_line) begin
      host_oe <= 1'b0;
    end
    repeat (2) @(posedge ref_clk);
    shift_clk <= 1'b0;
  endtask : fall

  // One exchange: send the word, then read nread bits
  task automatic xfer(input logic [7:0]  word,
                      input int          nword,
                      input int          nread,
                      output logic [27:0] rx);
    logic b;
    rx = 28'h0;
    @(posedge ref_clk);
    select_n_powerdown <= 1'b0;
    for (int i = nword - 1; i >= 0; i--) begin
      host_d  <= word[i];
      host_oe <= 1'b1;
      rise(b);
      fall(i == 0);
    end
    for (int j = 0; j < nread; j++) begin
      rise(b);
      rx = {rx[26:0], b};
      fall(1'b0);
    end
    @(posedge ref_clk);
    select_n_powerdown <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : xfer

endmodule : acsp_host

// ===== testbench.sv
`timescale 1ns/100ps

module testbench;
  // ****************************************************************
  // Clock, reset and the two converter variants
  // ****************************************************************
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        noise   = 1'b0;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  logic [11:0] lvl_c = 12'h000;
  logic [11:0] lvl_f = 12'h000;
  logic        sel_c, clk_c, hd_c, hoe_c, dout_c, oe_c, core_c, wire_c;
  logic        sel_f, clk_f, hd_f, hoe_f, dout_f, oe_f, core_f, wire_f;
  logic        pos_c, gnd_c, neg_c, pos_f, gnd_f, neg_f;
  logic        track_c, track_f;
  logic [11:0] dac_c, dac_f;

  always #5 ref_clk = ~ref_clk;
  // A released line wanders so a stale value cannot pass
  always @(posedge ref_clk) noise <= ~noise;
  assign wire_c = oe_c ? dout_c : (hoe_c ? hd_c : noise);
  assign wire_f = oe_f ? dout_f : (hoe_f ? hd_f : noise);

  acsp_host host_cfg (.ref_clk(ref_clk), .data_wire(wire_c),
    .select_n_powerdown(sel_c), .shift_clk(clk_c), .host_d(hd_c),
    .host_oe(hoe_c));
  acsp_host host_fix (.ref_clk(ref_clk), .data_wire(wire_f),
    .select_n_powerdown(sel_f), .shift_clk(clk_f), .host_d(hd_f),
    .host_oe(hoe_f));

  acsp_port #(.FIXED_INPUT(1'b0)) acsp_port_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .select_n_powerdown(sel_c), .shift_clk(clk_c),
    .data_in(wire_c), .comp_ge(lvl_c >= dac_c), .data_out(dout_c),
    .data_out_oe(oe_c), .core_active(core_c), .sample_track(track_c),
    .dac_code(dac_c), .pos_is_input_one(pos_c), .neg_is_ground(gnd_c),
    .neg_is_input_one(neg_c));
  acsp_port #(.FIXED_INPUT(1'b1)) acsp_port_fix_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .select_n_powerdown(sel_f), .shift_clk(clk_f),
    .data_in(wire_f), .comp_ge(lvl_f >= dac_f), .data_out(dout_f),
    .data_out_oe(oe_f), .core_active(core_f), .sample_track(track_f),
    .dac_code(dac_f), .pos_is_input_one(pos_f), .neg_is_ground(gnd_f),
    .neg_is_input_one(neg_f));

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Null, MSB first, optional repeat from B1 up, zero fill
  function automatic logic [27:0] frame(logic [11:0] v, logic ord);
    logic [27:0] r;
    r = {1'b0, v, 15'h0};
    if (!ord) begin
      for (int i = 1; i < 12; i++) begin
        r[15-i] = v[i];
      end
    end
    return r;
  endfunction : frame

  // Both parties driving the line at once is a conflict
  always @(negedge ref_clk) begin
    if ((hoe_c & oe_c) | (hoe_f & oe_f)) begin
      check(28'h1, 28'h0);
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every pairing code, both orders, zero to three leading zeros
  task automatic test_cfg_modes();
    logic [27:0] rx;
    logic        sgl, odd, ord;
    for (int m = 0; m < 4; m++) begin
      sgl = m[1];
      odd = m[0];
      ord = m[1] ^ m[0];
      lvl_c <= (m == 0) ? 12'hFFF : 12'h5A3 + 12'h111 * m;
      host_cfg.xfer({4'h1, sgl, odd, ord} , 4 + m, 28, rx);
      check(rx, frame(lvl_c, ord));
      check(rx[3:0], 28'h0);
      check(pos_c, odd);
      check(gnd_c, sgl);
      check(neg_c, !sgl && !odd);
      check({oe_c, core_c, track_c}, 28'h0);
    end
  endtask : test_cfg_modes

  // Fixed variant: no word, two lead pulses, repeat always follows
  task automatic test_fixed();
    logic [27:0] rx;
    lvl_f <= 12'h000;
    host_fix.xfer(8'h00, 2, 28, rx);
    check(rx, frame(12'h000, 1'b0));
    lvl_f <= 12'hC35;
    host_fix.xfer(8'hFF, 2, 28, rx);
    check(rx, frame(12'hC35, 1'b0));
    check({pos_f, gnd_f, neg_f}, 28'h1);
    check({oe_f, core_f, track_f}, 28'h0);
  endtask : test_fixed

  // Abort in mid-conversion, then an MSB-only read ends after B0
  task automatic test_abort();
    logic [27:0] rx;
    lvl_c <= 12'h801;
    host_cfg.xfer(8'h0D, 4, 4, rx);
    check({oe_c, core_c, track_c}, 28'h0);
    check(rx[3:0], {1'b0, 3'h4});
    host_cfg.xfer(8'h0E, 4, 13, rx);
    check(rx[12:0], {1'b0, 12'h801});
  endtask : test_abort

  // Clocks and ones while deselected start nothing
  task automatic test_idle_clock();
    logic b;
    host_cfg.host_d  <= 1'b1;
    host_cfg.host_oe <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      host_cfg.rise(b);
      host_cfg.fall(i == 5);
      check({oe_c, core_c, track_c}, 28'h0);
    end
  endtask : test_idle_clock

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    test_idle_clock();
    test_cfg_modes();
    test_fixed();
    test_abort();
    final_report();
  end

  // Whole run needs about 1860 cycles; allow a wide margin
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    final_report();
  end

endmodule : testbench
